/* File: core/dcxe_decode.v */
`timescale 1ns/100ps
`default_nettype none
`include "dcxe_defs.vh"
// ==========================================================
// instruction field decoder
module dcxe_decode (
    // instruction bytes
    input wire [15:0] instr_head,
    // decoded fields
    output reg [3:0] op,
    output reg [2:0] len,
    output wire [4:0] num_field,
    output wire [2:0] rd_field,
    output wire inval_bit,
    output wire burst_select_bit,
    output wire cond_bit
);
    wire [7:0] b0;
    assign b0 = instr_head[7:0];
    // shared field positions
    assign num_field = instr_head[15:11];
    assign rd_field = instr_head[10:8];
    assign inval_bit = instr_head[9];
    assign burst_select_bit = b0[1];
    assign cond_bit = b0[0];
    // opcode classification
    always @* begin
        op = `DCXE_OP_BAD;
        len = `DCXE_LEN_1;
        if (b0 == `DCXE_ENC_MOV) begin
            op = `DCXE_OP_MOV;
            len = `DCXE_LEN_6;
        end else if (b0 == `DCXE_ENC_NOP) begin
            op = `DCXE_OP_NOP;
        end else if (b0 == `DCXE_ENC_RMB) begin
            op = `DCXE_OP_RMB;
        end else if (b0 == `DCXE_ENC_SEV) begin
            op = `DCXE_OP_SEV;
            len = `DCXE_LEN_2;
        end else if (b0 == `DCXE_ENC_WFE) begin
            op = `DCXE_OP_WFE;
            len = `DCXE_LEN_2;
        end else if (b0 == `DCXE_ENC_STZ) begin
            op = `DCXE_OP_STZ;
        end else if (b0[7:2] == `DCXE_ENC_ST) begin
            op = `DCXE_OP_ST;
        end else if (b0[7:2] == `DCXE_ENC_STP && b0[0]) begin
            op = `DCXE_OP_STP;
            len = `DCXE_LEN_2;
        end else if (b0[7:2] == `DCXE_ENC_LPENDFE) begin
            op = `DCXE_OP_LPEND;
            len = `DCXE_LEN_2;
        end
    end
endmodule // dcxe_decode
`default_nettype wire

/* File: core/dcxe_defs.vh */
`ifndef DCXE_DEFS_VH
`define DCXE_DEFS_VH
// ==========================================================
// register offsets (byte addresses)
`define DCXE_OFF_SRC 8'h00
`define DCXE_OFF_DST 8'h04
`define DCXE_OFF_CTL 8'h08
`define DCXE_OFF_INTEN 8'h0C
`define DCXE_OFF_EVENT 8'h10
`define DCXE_OFF_IRQ 8'h14
`define DCXE_OFF_STATUS 8'h18
// ==========================================================
// reset values
`define DCXE_RST_WORD 32'h00000000
// ==========================================================
// channel control fields
`define DCXE_CTL_DINC 14
`define DCXE_CTL_DSIZE_LO 15
`define DCXE_CTL_DSIZE_HI 17
`define DCXE_CTL_DLEN_LO 18
`define DCXE_CTL_DLEN_HI 21
// ==========================================================
// first instruction byte encodings
`define DCXE_ENC_MOV 8'hBC
`define DCXE_ENC_NOP 8'h18
`define DCXE_ENC_RMB 8'h12
`define DCXE_ENC_SEV 8'h34
`define DCXE_ENC_WFE 8'h36
`define DCXE_ENC_STZ 8'h0C
`define DCXE_ENC_ST 6'h02
`define DCXE_ENC_STP 6'h0A
`define DCXE_ENC_LPENDFE 6'h0B
// ==========================================================
// move register selects
`define DCXE_RD_SRC 3'h0
`define DCXE_RD_CTL 3'h1
`define DCXE_RD_DST 3'h2
// ==========================================================
// decoded operation classes
`define DCXE_OP_BAD 4'h0
`define DCXE_OP_NOP 4'h1
`define DCXE_OP_MOV 4'h2
`define DCXE_OP_RMB 4'h3
`define DCXE_OP_SEV 4'h4
`define DCXE_OP_WFE 4'h5
`define DCXE_OP_ST 4'h6
`define DCXE_OP_STP 4'h7
`define DCXE_OP_STZ 4'h8
`define DCXE_OP_LPEND 4'h9
// ==========================================================
// instruction lengths in bytes
`define DCXE_LEN_1 3'h1
`define DCXE_LEN_2 3'h2
`define DCXE_LEN_6 3'h6
// ==========================================================
// peripheral acknowledge types
`define DCXE_ACK_NONE 2'h0
`define DCXE_ACK_SINGLE 2'h1
`define DCXE_ACK_BURST 2'h2
`endif

/* File: core/dcxe_exec.v */
`timescale 1ns/100ps
`default_nettype none
`include "dcxe_defs.vh"
// Function
// - move-immediate writes 32-bit immediate to the selected register
// - register select 0 source, 1 control, 2 destination address
// - no-operation only advances the program counter, in any thread
// - read barrier stalls until all executed loads have completed
// - send-event raises the interrupt if enabled, else raises the event
// - event number is five bits; unimplemented events abort the thread
// - send-event is accepted in manager and channel threads
// - plain store moves fifo data to destination per control register
// - every executed store advances destination address when incrementing
// - single-conditional store under single request uses write length zero
// - mismatched conditional store behaves as no-operation
// - burst-conditional needs burst request; unconditional store always executes
// - a plain or peripheral store burst starts only when the fifo holds the whole burst
// - peripheral store reads channel fifo; ack type after write response
// - peripheral number is five bits; single variant always writes length one
// - zero store writes all-zero data with control burst attributes
// - event wait halts until event, then resumes and clears the event
// - invalidate bit of event wait invalidates this thread's instruction cache
// - conditional stores test request type set by last peripheral wait
// - forever loop end jumps back until last flag, then falls through
module dcxe_exec #(
    parameter DATA_W = 32,
    parameter NUM_EVENTS = 16,
    parameter CHANNEL = 0
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // instruction stream
    input wire [47:0] instr,
    input wire instr_valid,
    input wire manager_thread,
    output reg instr_done,
    output reg [2:0] instr_len,
    output reg pc_jump,
    output reg [7:0] jump_back,
    output reg thread_abort,
    output reg icache_invalidate,
    // request flags and load tracking
    input wire req_type_burst,
    input wire req_last,
    input wire loads_pending,
    // events and interrupts
    input wire [31:0] event_set,
    output reg [31:0] irq,
    output wire [31:0] event_flags,
    // shared data fifo
    input wire [4:0] fifo_level,
    input wire [DATA_W-1:0] fifo_data,
    output wire fifo_pop,
    output wire [2:0] fifo_chan,
    // write address channel
    output reg [31:0] awaddr,
    output reg [3:0] awlen,
    output reg [2:0] awsize,
    output reg [1:0] awburst,
    output reg awvalid,
    input wire awready,
    // write data channel
    output reg [DATA_W-1:0] wdata,
    output wire [DATA_W/8-1:0] wstrb,
    output reg wlast,
    output reg wvalid,
    input wire wready,
    // write response channel
    output wire bready,
    input wire bvalid,
    // peripheral acknowledge
    output reg [1:0] ack_type,
    output reg [4:0] ack_periph
);
    localparam ST_IDLE = 3'h0;
    localparam ST_RMB = 3'h1;
    localparam ST_WFE = 3'h2;
    localparam ST_FIFO = 3'h3;
    localparam ST_AW = 3'h4;
    localparam ST_W = 3'h5;
    localparam ST_B = 3'h6;

    reg [2:0] state_reg;
    reg [31:0] src_reg;
    reg [31:0] dst_reg;
    reg [31:0] ctl_reg;
    reg [31:0] inten_reg;
    reg [31:0] event_reg;
    reg [31:0] event_next;
    reg [3:0] len_reg;
    reg [3:0] beats_reg;
    reg zero_reg;
    reg periph_reg;
    reg [4:0] num_reg;
    reg inval_reg;
    reg sev_fire;
    reg wfe_clear;

    wire [3:0] op;
    wire [2:0] dec_len;
    wire [4:0] num_field;
    wire [2:0] rd_field;
    wire inval_bit;
    wire bs_bit;
    wire cond_bit;
    wire accept;
    wire store_go;
    wire pulse_busy;
    wire w_load;
    wire [3:0] ctl_len;
    wire [2:0] ctl_size;
    wire ctl_inc;
    wire [35:0] step_bytes;

    // ==========================================================
    // decode
    dcxe_decode u_decode (
        .instr_head(instr[15:0]),
        .op(op),
        .len(dec_len),
        .num_field(num_field),
        .rd_field(rd_field),
        .inval_bit(inval_bit),
        .burst_select_bit(bs_bit),
        .cond_bit(cond_bit)
    );

    // control register fields
    assign ctl_len = ctl_reg[`DCXE_CTL_DLEN_HI:`DCXE_CTL_DLEN_LO];
    assign ctl_size = ctl_reg[`DCXE_CTL_DSIZE_HI:`DCXE_CTL_DSIZE_LO];
    assign ctl_inc = ctl_reg[`DCXE_CTL_DINC];
    assign step_bytes = {32'h00000000, len_reg + 4'h1} << ctl_size;

    // one instruction in flight; wait for the previous pulse to clear
    assign pulse_busy = instr_done | pc_jump | thread_abort;
    assign accept = instr_valid & (state_reg == ST_IDLE) & ~pulse_busy;
    // conditional match against the last peripheral wait
    assign store_go = ~cond_bit | (bs_bit == req_type_burst);

    // fifo and data path
    assign fifo_chan = CHANNEL[2:0];
    assign w_load = (state_reg == ST_W) & (~wvalid | wready) & (beats_reg != 4'h0);
    assign fifo_pop = w_load & ~zero_reg;
    assign wstrb = {(DATA_W/8){1'b1}};
    assign bready = (state_reg == ST_B);
    assign event_flags = event_reg;

    // ==========================================================
    // event flags: set wins over clear
    always @* begin
        event_next = event_reg;
        if (wfe_clear) begin
            event_next[num_reg] = 1'b0;
        end
        if (sev_fire && !inten_reg[num_reg]) begin
            event_next[num_reg] = 1'b1;
        end
        event_next = event_next | event_set;
    end

    // ==========================================================
    // execution state machine
    always @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            src_reg <= `DCXE_RST_WORD;
            dst_reg <= `DCXE_RST_WORD;
            ctl_reg <= `DCXE_RST_WORD;
            instr_done <= 1'b0;
            instr_len <= 3'h0;
            pc_jump <= 1'b0;
            jump_back <= 8'h00;
            thread_abort <= 1'b0;
            icache_invalidate <= 1'b0;
            len_reg <= 4'h0;
            beats_reg <= 4'h0;
            zero_reg <= 1'b0;
            periph_reg <= 1'b0;
            num_reg <= 5'h00;
            inval_reg <= 1'b0;
            awaddr <= 32'h00000000;
            awlen <= 4'h0;
            awsize <= 3'h0;
            awburst <= 2'h0;
            awvalid <= 1'b0;
            wdata <= {DATA_W{1'b0}};
            wlast <= 1'b0;
            wvalid <= 1'b0;
            ack_type <= `DCXE_ACK_NONE;
            ack_periph <= 5'h00;
        end else begin
            instr_done <= 1'b0;
            pc_jump <= 1'b0;
            thread_abort <= 1'b0;
            icache_invalidate <= 1'b0;
            ack_type <= `DCXE_ACK_NONE;
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        instr_len <= dec_len;
                        num_reg <= num_field;
                        inval_reg <= inval_bit;
                        zero_reg <= (op == `DCXE_OP_STZ);
                        periph_reg <= (op == `DCXE_OP_STP);
                        // single variants always use one beat
                        len_reg <= (cond_bit && !bs_bit) ? 4'h0 : ctl_len;
                        case (op)
                            `DCXE_OP_NOP: begin
                                instr_done <= 1'b1;
                            end
                            `DCXE_OP_MOV: begin
                                if (manager_thread) begin
                                    thread_abort <= 1'b1;
                                end else if (rd_field == `DCXE_RD_SRC) begin
                                    src_reg <= instr[47:16];
                                    instr_done <= 1'b1;
                                end else if (rd_field == `DCXE_RD_CTL) begin
                                    ctl_reg <= instr[47:16];
                                    instr_done <= 1'b1;
                                end else if (rd_field == `DCXE_RD_DST) begin
                                    dst_reg <= instr[47:16];
                                    instr_done <= 1'b1;
                                end else begin
                                    thread_abort <= 1'b1;
                                end
                            end
                            `DCXE_OP_RMB: begin
                                if (manager_thread) begin
                                    thread_abort <= 1'b1;
                                end else begin
                                    state_reg <= ST_RMB;
                                end
                            end
                            `DCXE_OP_SEV: begin
                                if (num_field >= NUM_EVENTS) begin
                                    thread_abort <= 1'b1;
                                end else begin
                                    instr_done <= 1'b1;
                                end
                            end
                            `DCXE_OP_WFE: begin
                                if (manager_thread || num_field >= NUM_EVENTS) begin
                                    thread_abort <= 1'b1;
                                end else begin
                                    state_reg <= ST_WFE;
                                end
                            end
                            `DCXE_OP_ST, `DCXE_OP_STP, `DCXE_OP_STZ: begin
                                if (manager_thread) begin
                                    thread_abort <= 1'b1;
                                end else if (op == `DCXE_OP_STZ) begin
                                    state_reg <= ST_AW;
                                end else if (store_go) begin
                                    state_reg <= ST_FIFO;
                                end else begin
                                    instr_done <= 1'b1;
                                end
                            end
                            `DCXE_OP_LPEND: begin
                                if (req_last) begin
                                    instr_done <= 1'b1;
                                end else begin
                                    pc_jump <= 1'b1;
                                    jump_back <= instr[15:8];
                                end
                            end
                            default: begin
                                thread_abort <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_RMB: begin
                    if (!loads_pending) begin
                        instr_done <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_WFE: begin
                    if (event_reg[num_reg]) begin
                        instr_done <= 1'b1;
                        icache_invalidate <= inval_reg;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_FIFO: begin
                    if ({1'b0, fifo_level} > {2'b00, len_reg}) begin
                        state_reg <= ST_AW;
                    end
                end
                ST_AW: begin
                    if (!awvalid) begin
                        awvalid <= 1'b1;
                        awaddr <= dst_reg;
                        awlen <= len_reg;
                        awsize <= ctl_size;
                        awburst <= {1'b0, ctl_inc};
                    end else if (awready) begin
                        awvalid <= 1'b0;
                        beats_reg <= len_reg + 4'h1;
                        state_reg <= ST_W;
                    end
                end
                ST_W: begin
                    if (w_load) begin
                        wvalid <= 1'b1;
                        wdata <= zero_reg ? {DATA_W{1'b0}} : fifo_data;
                        wlast <= (beats_reg == 4'h1);
                        beats_reg <= beats_reg - 4'h1;
                    end else if (wvalid && wready) begin
                        wvalid <= 1'b0;
                        wlast <= 1'b0;
                        if (wlast) begin
                            state_reg <= ST_B;
                        end
                    end
                end
                ST_B: begin
                    if (bvalid) begin
                        state_reg <= ST_IDLE;
                        instr_done <= 1'b1;
                        if (ctl_inc) begin
                            dst_reg <= dst_reg + step_bytes[31:0];
                        end
                        if (periph_reg) begin
                            ack_periph <= num_reg;
                            ack_type <= (len_reg == 4'h0) ? `DCXE_ACK_SINGLE : `DCXE_ACK_BURST;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // event, interrupt, enable registers and send-event strobes
    always @(posedge clock) begin
        if (rst) begin
            inten_reg <= `DCXE_RST_WORD;
            event_reg <= `DCXE_RST_WORD;
            irq <= 32'h00000000;
            sev_fire <= 1'b0;
            wfe_clear <= 1'b0;
        end else begin
            sev_fire <= accept & (op == `DCXE_OP_SEV) & (num_field < NUM_EVENTS);
            wfe_clear <= (state_reg == ST_WFE) & event_reg[num_reg];
            event_reg <= event_next;
            if (reg_wr && reg_addr == `DCXE_OFF_INTEN) begin
                inten_reg <= reg_wdata;
            end
            // interrupt: sev raise wins over software write-one clear
            if (reg_wr && reg_addr == `DCXE_OFF_IRQ) begin
                irq <= (irq & ~reg_wdata) |
                    ({32{sev_fire & inten_reg[num_reg]}} & (32'h00000001 << num_reg));
            end else if (sev_fire && inten_reg[num_reg]) begin
                irq[num_reg] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // read data one cycle after the strobe
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == `DCXE_OFF_SRC) begin
                reg_rdata <= src_reg;
            end else if (reg_addr == `DCXE_OFF_DST) begin
                reg_rdata <= dst_reg;
            end else if (reg_addr == `DCXE_OFF_CTL) begin
                reg_rdata <= ctl_reg;
            end else if (reg_addr == `DCXE_OFF_INTEN) begin
                reg_rdata <= inten_reg;
            end else if (reg_addr == `DCXE_OFF_EVENT) begin
                reg_rdata <= event_reg;
            end else if (reg_addr == `DCXE_OFF_IRQ) begin
                reg_rdata <= irq;
            end else if (reg_addr == `DCXE_OFF_STATUS) begin
                reg_rdata <= {27'h0000000, req_last, req_type_burst, state_reg};
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // dcxe_exec
`default_nettype wire

/* File: dv/dcxe_axi_mem.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// write slave, half rate when slow
module dcxe_axi_mem (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic slow,
    // write channels
    input wire logic awvalid,
    output logic awready,
    input wire logic wvalid,
    input wire logic wlast,
    input wire logic [31:0] wdata,
    output logic wready,
    input wire logic bready,
    output logic bvalid,
    output logic [31:0] last_wdata
);
    logic tick_reg = 1'b0, aw_reg = 1'b0, w_reg = 1'b0, b_reg = 1'b0;
    wire go = !rst && (!slow || tick_reg);
    assign awready = aw_reg;
    assign wready = w_reg;
    assign bvalid = b_reg;
    // ready pulses and response
    always @(posedge clock) begin
        tick_reg <= !tick_reg && !rst;
        aw_reg <= go && awvalid && !aw_reg;
        w_reg <= go && wvalid && !w_reg;
        b_reg <= !rst && (b_reg ? !bready : wvalid && w_reg && wlast);
        if (wvalid && w_reg)
            last_wdata <= wdata;
    end
endmodule // dcxe_axi_mem
`default_nettype wire

/* File: dv/dcxe_exec_props.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checker
module dcxe_exec_props #(
    parameter DATA_W = 32,
    parameter NUM_EVENTS = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // instruction side
    input wire logic [47:0] instr,
    input wire logic instr_done,
    input wire logic [2:0] instr_len,
    input wire logic pc_jump,
    input wire logic [7:0] jump_back,
    input wire logic icache_invalidate,
    // flags
    input wire logic req_type_burst,
    input wire logic req_last,
    input wire logic loads_pending,
    input wire logic [4:0] fifo_level,
    // write channels
    input wire logic awvalid,
    input wire logic [3:0] awlen,
    input wire logic wvalid,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] ack_type
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_mov_len: assert property (
        instr_done && $past(instr[7:0]) == 8'hBC |-> instr_len == 3'h6) else $error("move length");
    a_event_range: assert property (
        instr_done && $past(instr[7:0]) == 8'h34 |-> $past(instr[15:11]) < NUM_EVENTS)
        else $error("event range");
    a_rmb_waits: assert property (
        instr_done && $past(instr[7:0]) == 8'h12 |-> !$past(loads_pending)) else $error("barrier");
    a_mismatch_quiet: assert property (
        instr[7:0] == 8'h09 && req_type_burst |-> !awvalid) else $error("mismatch wrote");
    a_single_len: assert property (
        awvalid && (instr[7:0] inside {8'h09, 8'h29}) |-> awlen == 4'h0)
        else $error("single store length");
    a_fifo_ready: assert property (
        $rose(awvalid) && instr[7:0] != 8'h0C |-> $past(fifo_level) > {1'b0, awlen})
        else $error("fifo early");
    a_zero_data: assert property (
        wvalid && instr[7:0] == 8'h0C |-> wdata == '0) else $error("zero store data");
    a_ack_resp: assert property (
        ack_type != 2'h0 |-> $past(bvalid && bready)) else $error("ack early");
    a_inval_wfe: assert property (
        instr_done && $past(instr[7:0]) == 8'h36 |-> icache_invalidate == $past(instr[9]))
        else $error("invalidate");
    a_loop_back: assert property (
        pc_jump |-> !$past(req_last) && jump_back == $past(instr[15:8])) else $error("loop jump");
    // main scenarios reached
    c_jump: cover property (pc_jump);
    c_burst_ack: cover property (ack_type == 2'h2);
    c_inval: cover property (icache_invalidate);
endmodule // dcxe_exec_props
bind dcxe_exec dcxe_exec_props #(.DATA_W(DATA_W), .NUM_EVENTS(NUM_EVENTS)) u_props (.*);
`default_nettype wire

/* File: dv/dcxe_exec_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// self-checking bench
module dcxe_exec_tb;
    typedef struct packed {
        logic [47:0] i;
        logic [2:0] f;
        logic [1:0] e;
        logic [2:0] n;
        logic [1:0] a;
    } dcxe_row_t;
    logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, instr_valid = 1'b0;
    logic manager_thread = 1'b0, req_type_burst = 1'b0, req_last = 1'b0, slow = 1'b0;
    logic loads_pending = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, event_set = 32'h0, fifo_data = 32'hA5C3_0F1E;
    logic [47:0] instr = 48'h0;
    logic [4:0] fifo_level = 5'h10;
    logic [31:0] reg_rdata, irq, event_flags, wdata, last_wdata;
    logic [2:0] instr_len;
    logic [7:0] jump_back;
    logic [3:0] awlen;
    logic [1:0] ack_type;
    logic instr_done, pc_jump, thread_abort, icache_invalidate, awvalid, awready;
    logic wlast, wvalid, wready, bready, bvalid;
    int n_mismatch = 0, checks_done = 0;
    dcxe_row_t rows [22] = '{
        '{48'h18,3'h4,2'h0,3'h1,2'h0},'{48'h18,3'h0,2'h0,3'h1,2'h0},
        '{48'h1122_3344_00BC,3'h0,2'h0,3'h6,2'h0},'{48'h5_4000_01BC,3'h0,2'h0,3'h6,2'h0},
        '{48'h1000_02BC,3'h0,2'h0,3'h6,2'h0},'{48'hBC,3'h4,2'h1,3'h0,2'h0},
        '{48'h03BC,3'h0,2'h1,3'h0,2'h0},'{48'h12,3'h0,2'h0,3'h1,2'h0},
        '{48'h1834,3'h0,2'h0,3'h2,2'h0},'{48'h1A36,3'h0,2'h0,3'h2,2'h0},
        '{48'hA034,3'h0,2'h1,3'h0,2'h0},'{48'h09,3'h2,2'h0,3'h1,2'h0},
        '{48'h0B,3'h0,2'h0,3'h1,2'h0},'{48'h282B,3'h0,2'h0,3'h2,2'h0},
        '{48'h08,3'h0,2'h0,3'h1,2'h0},'{48'h0C,3'h0,2'h0,3'h1,2'h0},
        '{48'h09,3'h0,2'h0,3'h1,2'h0},'{48'h3829,3'h0,2'h0,3'h2,2'h1},
        '{48'h282B,3'h2,2'h0,3'h2,2'h2},'{48'h102C,3'h0,2'h2,3'h0,2'h0},
        '{48'h102C,3'h1,2'h0,3'h2,2'h0},'{48'h04,3'h0,2'h1,3'h0,2'h0}};
    dcxe_exec dut (.*, .fifo_pop(), .fifo_chan(), .awaddr(), .awsize(), .awburst(), .wstrb(),
        .ack_periph());
    dcxe_axi_mem mem (.*);
    // free-running clock
    initial forever #4 clock = ~clock;
    // compare and count
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one register cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    // one instruction, wait for pulse
    task automatic exec(input dcxe_row_t r);
        int k;
        logic [1:0] got;
        @(posedge clock);
        instr <= r.i;
        manager_thread <= r.f[2];
        req_type_burst <= r.f[1];
        req_last <= r.f[0];
        instr_valid <= 1'b1;
        got = 2'h3;
        for (k = 0; k < 300 && got == 2'h3; k++) begin
            @(posedge clock);
            #1 got = instr_done ? 2'h0 : thread_abort ? 2'h1 : pc_jump ? 2'h2 : 2'h3;
        end
        chk("outcome", got, r.e);
        if (got == 2'h0)
            chk("length", instr_len, r.n);
        chk("ack type", ack_type, r.a);
        if (got == 2'h3)
            final_report;
        @(posedge clock);
        instr_valid <= 1'b0;
    endtask
    // held instruction, then release
    task automatic stall(input dcxe_row_t r, input string nm);
        fork
            exec(r);
            begin
                repeat (10) @(posedge clock);
                #1 chk(nm, {awvalid, instr_done}, 2'h0);
                @(posedge clock);
                fifo_level <= 5'h10;
                loads_pending <= 1'b0;
                event_set <= 32'h10;
                @(posedge clock);
                event_set <= 32'h0;
            end
        join
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", reg_rdata, 32'h0);
        chk("irq reset", irq, 32'h0);
        $display("reset test done");
        foreach (rows[j]) exec(rows[j]);
        bus(1'b0, 8'h00, 32'h0);
        chk("source", reg_rdata, 32'h1122_3344);
        bus(1'b0, 8'h08, 32'h0);
        chk("control", reg_rdata, 32'h0005_4000);
        bus(1'b0, 8'h04, 32'h0);
        chk("destination", reg_rdata, 32'h0000_1020);
        chk("store data", last_wdata, fifo_data);
        chk("events", event_flags, 32'h0);
        $display("table test done");
        bus(1'b1, 8'h0C, 32'h200);
        exec('{48'h4834,3'h4,2'h0,3'h2,2'h0});
        #1 chk("irq", irq, 32'h200);
        chk("no event", event_flags, 32'h0);
        $display("interrupt test done");
        @(posedge clock);
        loads_pending <= 1'b1;
        stall('{48'h12,3'h0,2'h0,3'h1,2'h0}, "barrier");
        @(posedge clock);
        slow <= 1'b1;
        fifo_level <= 5'h01;
        stall('{48'h08,3'h0,2'h0,3'h1,2'h0}, "fifo wait");
        exec('{48'h2034,3'h0,2'h0,3'h2,2'h0});
        exec('{48'h2236,3'h0,2'h0,3'h2,2'h0});
        stall('{48'h2036,3'h0,2'h0,3'h2,2'h0}, "event wait");
        bus(1'b0, 8'h04, 32'h0);
        chk("destination", reg_rdata, 32'h0000_1028);
        chk("events", event_flags, 32'h0);
        $display("stall test done");
        final_report;
    end
endmodule // dcxe_exec_tb
`default_nettype wire
